// File: core/buck_seq_defines.svh
// Constants for the buck startup and fault sequencer
`ifndef BUCK_SEQ_DEFINES_SVH
`define BUCK_SEQ_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define SEQ_REG_CTRL 8'h00
`define SEQ_REG_STATUS 8'h04
`define SEQ_REG_SSREF 8'h08
`define SEQ_REG_HICCUPS 8'h0C

// ==========================================================
// Field positions and reset values
`define SEQ_CTRL_EN_BIT 0
`define SEQ_CTRL_RST 1'b1

// ==========================================================
// Timebase and timing figures
`define SEQ_CLK_MHZ 50
`define SEQ_TICK_NS 1000
`define SEQ_TICK_CYC (`SEQ_TICK_NS * `SEQ_CLK_MHZ / 1000)
`define SEQ_SS_FINAL_MV 1500
`define SEQ_SS_SLOPE_UV_PER_US 400
`define SEQ_SS_TICKS (`SEQ_SS_FINAL_MV * 1000 / `SEQ_SS_SLOPE_UV_PER_US)
`define SEQ_HICCUP_US 20480
`define SEQ_SAMPLE_NS 30
`define SEQ_SAMPLE_CYC ((`SEQ_SAMPLE_NS * `SEQ_CLK_MHZ + 999) / 1000)
`define SEQ_SHORT_NS 40
`define SEQ_SHORT_CYC (`SEQ_SHORT_NS * `SEQ_CLK_MHZ / 1000)
`define SEQ_PB_PULSES 16
`define SEQ_PB_STEPS 8
`define SEQ_ZC_CYCLES 256

`endif

// File: core/buck_seq_pkg.sv
// Types shared by the buck startup and fault sequencer
package buck_seq_pkg;

  // ========================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0]
  {
    ST_OFF = 5'b00001,
    ST_SOFT = 5'b00010,
    ST_RUN = 5'b00100,
    ST_HICCUP = 5'b01000,
    ST_HOT = 5'b10000
  } seq_state_e;

  // ========================================================
  // Comparator and strap inputs, as one bundle
  typedef struct packed
  {
    logic [1:0] strap;
    logic ovp;
    logic hot;
    logic zc;
    logic oc;
    logic osc;
    logic pwm;
    logic en;
    logic bias;
  } pin_s;

  // ========================================================
  // Whole state of the sequencer
  typedef struct packed
  {
    pin_s s1;
    pin_s s2;
    pin_s s3;
    pin_s flt;
    seq_state_e st;
    logic [5:0] tick_cnt;
    logic [11:0] ss_ref;
    logic [14:0] hic_cnt;
    logic [7:0] per_cnt;
    logic [7:0] per_len;
    logic [3:0] pb_step;
    logic [4:0] pb_pulse;
    logic hs_seen;
    logic ls_on;
    logic [7:0] ls_cnt;
    logic [7:0] ls_len;
    logic [1:0] samp_cnt;
    logic oc_lat;
    logic [8:0] zc_cnt;
    logic zc_seen;
    logic bias_low;
    logic hs_out;
    logic ls_out;
    logic sv;
    logic ctrl_en;
    logic [1:0] strap;
    logic strap_taken;
    logic [15:0] hiccups;
    logic [31:0] prdata;
  } seq_s;

endpackage

// File: core/buck_startup_fault_sequencer.sv
// Startup, pre-bias, current sampling and fault sequencer for a buck
//
// Contract
// - Drivers off unless bias and enable valid
// - Supply-valid flag launches soft-start
// - Turn on only above enable rising threshold
// - Enable low shuts both drivers off
// - Low side off until first high pulse
// - Low pulse starts at eighth, steps eighths
// - Sixteen pulses per step, eight steps
// - Reference ramps 0.4mV/us up to 1.5V
// - Overcurrent and overvoltage active during ramp
// - Current limit chosen from three-way strap
// - Sample 30ns, eighth period before valley
// - Short low pulse: sample 40ns in
// - Flag overcurrent when sample exceeds limit
// - Overcurrent latches, reference zero 20.48ms
// - After hiccup clear flag, restart, repeat
// - Thermal trip: switches off, ramp reset
// - Auto restart when temperature trip releases
// - Bias 4.4V light load, else 6.8V; code also selects 4.4V (bias_low high) from reset and while off
// - Support 300kHz to 1500kHz switching
// - Low bias after 256 zero-crossing cycles
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "buck_seq_defines.svh"

module buck_startup_fault_sequencer
#(
  parameter logic [11:0] SS_TICKS = 12'(`SEQ_SS_TICKS),
  parameter logic [14:0] HICCUP_TICKS = 15'(`SEQ_HICCUP_US)
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparators and straps
  input wire logic bias_ok,
  input wire logic enable_ok,
  input wire logic pwm_request,
  input wire logic osc_clock,
  input wire logic oc_over_limit,
  input wire logic zero_cross,
  input wire logic thermal_trip,
  input wire logic overvoltage,
  input wire logic [1:0] limit_select_strap,
  // Power stage and bias control
  output logic high_side_switch,
  output logic low_side_switch,
  output logic supply_valid,
  output logic [11:0] ss_ref,
  output logic oc_sample,
  output logic [1:0] oc_limit_sel,
  output logic bias_low,
  output logic oc_fault,
  output logic thermal_off
);

  buck_seq_pkg::seq_s q;
  buck_seq_pkg::seq_s d;
  buck_seq_pkg::pin_s pins;
  logic tick;
  logic osc_rise;
  logic supply_ok;
  logic drive_en;
  logic active;
  logic hs_fall;
  logic samp_on;
  logic oc_event;
  logic [15:0] lim16;
  logic [7:0] ls_limit;
  logic [7:0] eighth;
  logic apb_wr;
  logic apb_setup;
  logic mapped;

  // ========================================================
  // Pin bundle
  assign pins = '{strap: limit_select_strap, ovp: overvoltage,
                  hot: thermal_trip, zc: zero_cross, oc: oc_over_limit,
                  osc: osc_clock, pwm: pwm_request, en: enable_ok,
                  bias: bias_ok};

  // ========================================================
  // APB decode; zero wait states
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign mapped = (paddr == `SEQ_REG_CTRL) || (paddr == `SEQ_REG_STATUS) ||
                  (paddr == `SEQ_REG_SSREF) || (paddr == `SEQ_REG_HICCUPS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ========================================================
  // Next state of the whole sequencer
  always_comb
  begin
    d = q;
    // Three-stage pin sync; a change counts once stages 2 and 3 agree
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Hold the filtered bit while stages disagree, else follow stage 3
    d.flt = (q.flt & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
    osc_rise = d.flt.osc && !q.flt.osc;
    // Fixed microsecond timebase, independent of switching rate
    tick = (q.tick_cnt == 6'(`SEQ_TICK_CYC - 1));
    d.tick_cnt = tick ? 6'h00 : q.tick_cnt + 6'h01;
    // Comparators carry the 1.2V / 1.0V enable hysteresis
    supply_ok = q.flt.bias && q.flt.en && q.ctrl_en;
    active = (q.st == buck_seq_pkg::ST_SOFT) ||
             (q.st == buck_seq_pkg::ST_RUN);
    // Overvoltage cuts both drivers in ramp and run alike
    drive_en = supply_ok && active && !q.flt.hot &&
               !q.flt.ovp;
    d.sv = supply_ok;
    // Strap is static; catch it once the syncs have settled
    if (!q.strap_taken && tick)
    begin
      d.strap = q.flt.strap;
      d.strap_taken = 1'b1;
    end
    // Period measurement; widest period fits 8 bits at 300kHz
    d.per_cnt = (q.per_cnt == 8'hFF) ? q.per_cnt : q.per_cnt + 8'h01;
    if (osc_rise)
    begin
      d.per_len = q.per_cnt + 8'h01;
      d.per_cnt = 8'h00;
    end
    eighth = {3'b000, q.per_len[7:3]};
    // Low pulse length: period times step, in eighths
    lim16 = {8'h00, q.per_len} * {12'h000, q.pb_step};
    ls_limit = lim16[10:3];
    // High side follows the analog modulator
    d.hs_out = drive_en && q.flt.pwm;
    if (d.hs_out)
    begin
      d.hs_seen = 1'b1;
    end
    hs_fall = q.hs_out && !d.hs_out;
    // Low side runs from high-side fall for the allowed width
    if (hs_fall && q.hs_seen)
    begin
      d.ls_on = 1'b1;
      d.ls_cnt = 8'h00;
    end
    else if (q.ls_on)
    begin
      d.ls_cnt = q.ls_cnt + 8'h01;
      if (d.hs_out || osc_rise || (q.ls_cnt + 8'h01 >= ls_limit))
      begin
        d.ls_on = 1'b0;
        d.ls_len = q.ls_cnt + 8'h01;
      end
    end
    d.ls_out = drive_en && d.ls_on && !d.hs_out &&
               q.hs_seen;
    // Pre-bias steps counted in switching pulses
    if (osc_rise && q.hs_seen && q.pb_step != 4'(`SEQ_PB_STEPS))
    begin
      d.pb_pulse = q.pb_pulse + 5'h01;
      if (q.pb_pulse == 5'(`SEQ_PB_PULSES - 1))
      begin
        d.pb_pulse = 5'h00;
        d.pb_step = q.pb_step + 4'h1;
      end
    end
    // Valley sample window; short low pulses sample early
    if (q.ls_on && q.samp_cnt == 2'b00)
    begin
      if (q.ls_len >= eighth && q.per_cnt == q.per_len - eighth)
      begin
        d.samp_cnt = 2'(`SEQ_SAMPLE_CYC);
      end
      else if (q.ls_len < eighth && q.ls_cnt == 8'(`SEQ_SHORT_CYC))
      begin
        d.samp_cnt = 2'(`SEQ_SAMPLE_CYC);
      end
    end
    else if (q.samp_cnt != 2'b00)
    begin
      d.samp_cnt = q.samp_cnt - 2'b01;
    end
    samp_on = (q.samp_cnt != 2'b00) && q.ls_out;
    oc_event = samp_on && q.flt.oc && active;
    // Light-load detector drops gate bias after a long zc run
    if (q.flt.zc)
    begin
      d.zc_seen = 1'b1;
    end
    if (osc_rise && q.hs_seen)
    begin
      d.zc_seen = 1'b0;
      if (q.zc_seen)
      begin
        if (q.zc_cnt != 9'(`SEQ_ZC_CYCLES))
        begin
          d.zc_cnt = q.zc_cnt + 9'h001;
        end
        d.bias_low = (d.zc_cnt == 9'(`SEQ_ZC_CYCLES));
      end
      else
      begin
        d.zc_cnt = 9'h000;
        d.bias_low = 1'b0;
      end
    end
    // Sequencer state machine
    case (q.st)
      buck_seq_pkg::ST_OFF:
      begin
        d.ss_ref = 12'h000;
        d.bias_low = 1'b1;
        if (supply_ok)
        begin
          d.st = buck_seq_pkg::ST_SOFT;
          d.bias_low = 1'b0;
          d.zc_cnt = 9'h000;
        end
      end
      buck_seq_pkg::ST_SOFT, buck_seq_pkg::ST_RUN:
      begin
        if (q.st == buck_seq_pkg::ST_SOFT && tick)
        begin
          d.ss_ref = q.ss_ref + 12'h001;
          if (d.ss_ref == SS_TICKS)
          begin
            d.st = buck_seq_pkg::ST_RUN;
          end
        end
        if (!supply_ok)
        begin
          d.st = buck_seq_pkg::ST_OFF;
        end
        else if (q.flt.hot)
        begin
          d.st = buck_seq_pkg::ST_HOT;
          d.ss_ref = 12'h000;
        end
        else if (oc_event)
        begin
          d.st = buck_seq_pkg::ST_HICCUP;
          d.oc_lat = 1'b1;
          d.ss_ref = 12'h000;
          d.hic_cnt = 15'h0000;
          d.hiccups = q.hiccups + 16'h0001;
        end
      end
      buck_seq_pkg::ST_HICCUP:
      begin
        d.ss_ref = 12'h000;
        if (tick)
        begin
          d.hic_cnt = q.hic_cnt + 15'h0001;
        end
        if (!supply_ok)
        begin
          d.st = buck_seq_pkg::ST_OFF;
          d.oc_lat = 1'b0;
        end
        else if (tick && d.hic_cnt == HICCUP_TICKS)
        begin
          d.st = buck_seq_pkg::ST_SOFT;
          d.oc_lat = 1'b0;
        end
      end
      buck_seq_pkg::ST_HOT:
      begin
        d.ss_ref = 12'h000;
        if (!supply_ok)
        begin
          d.st = buck_seq_pkg::ST_OFF;
        end
        else if (!q.flt.hot)
        begin
          d.st = buck_seq_pkg::ST_SOFT;
        end
      end
      default:
      begin
        d.st = buck_seq_pkg::ST_OFF;
      end
    endcase
    // Each fresh start repeats the pre-bias pattern
    if (d.st == buck_seq_pkg::ST_SOFT && q.st != buck_seq_pkg::ST_SOFT)
    begin
      d.hs_seen = 1'b0;
      d.ls_on = 1'b0;
      d.pb_step = 4'h1;
      d.pb_pulse = 5'h00;
    end
    // Register writes take effect in the access phase
    if (apb_wr && paddr == `SEQ_REG_CTRL)
    begin
      d.ctrl_en = pwdata[`SEQ_CTRL_EN_BIT];
    end
    // Read data captured in setup so it stands registered
    if (apb_setup)
    begin
      case (paddr)
        `SEQ_REG_CTRL: d.prdata = {31'h0, q.ctrl_en};
        `SEQ_REG_STATUS: d.prdata = {18'h0, q.strap, q.sv, q.bias_low,
                                     q.oc_lat, q.pb_step, q.st};
        `SEQ_REG_SSREF: d.prdata = {20'h0, q.ss_ref};
        `SEQ_REG_HICCUPS: d.prdata = {16'h0, q.hiccups};
        default: d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.st <= buck_seq_pkg::ST_OFF;
      q.pb_step <= 4'h1;
      q.ctrl_en <= `SEQ_CTRL_RST;
      q.bias_low <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================
  // Outputs, all from flops
  assign prdata = q.prdata;
  assign high_side_switch = q.hs_out;
  assign low_side_switch = q.ls_out;
  assign supply_valid = q.sv;
  assign ss_ref = q.ss_ref;
  assign oc_sample = q.samp_cnt != 2'b00;
  assign oc_limit_sel = q.strap;
  assign bias_low = q.bias_low;
  assign oc_fault = q.oc_lat;
  assign thermal_off = q.st == buck_seq_pkg::ST_HOT;

  // ========================================================
  // Checks
  property p_supply_off;
    @(posedge pclk) disable iff (!presetn)
      (!q.flt.bias || !q.flt.en) |=> (!q.hs_out && !q.ls_out);
  endproperty
  a_supply_off: assert property (p_supply_off)
    else $error("driver on without valid supply");

  property p_sv_start;
    @(posedge pclk) disable iff (!presetn)
      $rose(q.sv) |-> (q.st == buck_seq_pkg::ST_SOFT);
  endproperty
  a_sv_start: assert property (p_sv_start)
    else $error("supply valid without soft-start");

  property p_ls_wait;
    @(posedge pclk) disable iff (!presetn)
      !q.hs_seen |-> !q.ls_out;
  endproperty
  a_ls_wait: assert property (p_ls_wait)
    else $error("low side before first high pulse");

  property p_ss_cap;
    @(posedge pclk) disable iff (!presetn)
      q.st == buck_seq_pkg::ST_RUN |-> q.ss_ref == SS_TICKS;
  endproperty
  a_ss_cap: assert property (p_ss_cap)
    else $error("ramp final value wrong");

  sequence s_oc_hit;
    oc_event && !q.flt.hot && supply_ok;
  endsequence
  property p_hiccup;
    @(posedge pclk) disable iff (!presetn)
      s_oc_hit |=> (q.oc_lat && q.ss_ref == 12'h000) ##1 q.ss_ref == 12'h000;
  endproperty
  a_hiccup: assert property (p_hiccup)
    else $error("hiccup not entered");

  property p_retry;
    @(posedge pclk) disable iff (!presetn)
      (q.st == buck_seq_pkg::ST_HICCUP && tick && supply_ok &&
       q.hic_cnt == HICCUP_TICKS - 15'h0001)
      |=> (q.st == buck_seq_pkg::ST_SOFT && !q.oc_lat);
  endproperty
  a_retry: assert property (p_retry)
    else $error("no retry after hiccup");

  property p_hot_off;
    @(posedge pclk) disable iff (!presetn)
      q.flt.hot |=> (!q.hs_out && !q.ls_out) ##1 (q.ss_ref == 12'h000 ||
                                                 !q.flt.hot);
  endproperty
  a_hot_off: assert property (p_hot_off)
    else $error("switch on during thermal trip");

  property p_bias_low;
    @(posedge pclk) disable iff (!presetn)
      (q.bias_low && q.st != buck_seq_pkg::ST_OFF) |->
        q.zc_cnt == 9'(`SEQ_ZC_CYCLES);
  endproperty
  a_bias_low: assert property (p_bias_low)
    else $error("low bias before 256 cycles");

endmodule

// File: tb/power_stage_model.sv
// Behavioural power stage and comparator model facing the sequencer
`timescale 1ns/1ps
module power_stage_model
#(
  parameter int PERIOD = 80,
  parameter int HIGH_CYC = 24
)
(
  // Clock
  input wire logic pclk,
  // Gate drives from the sequencer
  input wire logic low_side_switch,
  // Scenario controls
  input wire logic overload,
  input wire logic light_load,
  // Comparator outputs
  output logic osc_clock,
  output logic pwm_request,
  output logic oc_over_limit,
  output logic zero_cross
);
  // ========================================================
  // Oscillator and comparators
  int phase = 0;

  // Outputs start low so nothing is unknown before the first edge
  initial
  begin
    osc_clock = 1'b0;
    pwm_request = 1'b0;
    oc_over_limit = 1'b0;
    zero_cross = 1'b0;
  end

  // 625 kHz at a 20 ns clock, inside the supported range
  always @(posedge pclk)
  begin
    phase <= (phase + 1) % PERIOD;
    osc_clock <= (phase < PERIOD / 2);
    pwm_request <= (phase < HIGH_CYC);
    // Current is sensed only through a conducting low side
    oc_over_limit <= overload && low_side_switch;
    zero_cross <= light_load && low_side_switch;
  end
endmodule

// File: tb/tb.sv
// Self-checking testbench for the buck startup and fault sequencer
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bias_ok, enable_ok, pwm_request, osc_clock, oc_over_limit;
  logic zero_cross, thermal_trip, overvoltage, overload, light_load;
  logic [1:0] limit_select_strap, oc_limit_sel;
  logic high_side_switch, low_side_switch, supply_valid, oc_sample;
  logic bias_low, oc_fault, thermal_off, err;
  logic hs_seen = 1'b0;
  logic ls_early = 1'b0;
  logic [11:0] ss_ref;
  int n_errors = 0;
  int checks_done = 0;
  int lw_cnt = 0;
  int sw_cnt = 0;
  int sw_last = 0;
  int lw_q[$];

  // ==========================================================
  // Design and far side; short ramp and hiccup counts
  buck_startup_fault_sequencer #(.SS_TICKS(12'h014),
    .HICCUP_TICKS(15'h00A)) buck_startup_fault_sequencer_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bias_ok, .enable_ok, .pwm_request, .osc_clock,
    .oc_over_limit, .zero_cross, .thermal_trip, .overvoltage,
    .limit_select_strap, .high_side_switch, .low_side_switch,
    .supply_valid, .ss_ref, .oc_sample, .oc_limit_sel, .bias_low,
    .oc_fault, .thermal_off);
  power_stage_model power_stage_model_inst (.pclk, .low_side_switch,
    .overload, .light_load, .osc_clock, .pwm_request, .oc_over_limit,
    .zero_cross);

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Low pulse widths, sample window width, low side before high side
  always @(posedge pclk)
  begin
    if (!supply_valid || oc_fault || thermal_off)
      hs_seen <= 1'b0;
    else if (high_side_switch)
      hs_seen <= 1'b1;
    if (low_side_switch && !hs_seen && supply_valid)
      ls_early <= 1'b1;
    lw_cnt <= low_side_switch ? lw_cnt + 1 : 0;
    if (!low_side_switch && lw_cnt != 0)
      lw_q.push_back(lw_cnt);
    sw_cnt <= oc_sample ? sw_cnt + 1 : 0;
    if (!oc_sample && sw_cnt != 0)
      sw_last <= sw_cnt;
  end

  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return supply_valid;
      1: return oc_fault;
      2: return thermal_off;
      default: return bias_low;
    endcase
  endfunction

  // Bounded wait for a design flag to reach a level
  task automatic wait_for(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    check("wait", 32'(n < lim), 32'h1);
    if (n >= lim)
      stop_test();
  endtask

  // One APB transfer; read data taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      wait_for(0, ~supply_valid, 0);
    // Idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    check("hs", 32'(high_side_switch), 32'h0);
    check("bias", 32'(bias_low), 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", rd, 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    check("slverr", 32'(err), 32'h1);
    enable_ok <= 1'b0;
    bias_ok <= 1'b1;
    repeat (60) @(posedge pclk);
    check("sv_no_en", 32'(supply_valid), 32'h0);
  endtask

  task automatic t_start();
    int n;
    n = 0;
    lw_q.delete();
    enable_ok <= 1'b1;
    wait_for(0, 1'b1, 10);
    while (ss_ref !== 12'h001 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (ss_ref === 12'h001 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    check("ramp_step", 32'(n), 32'd50);
    repeat (12000) @(posedge pclk);
    check("ss_final", 32'(ss_ref), 32'h14);
    apb(1'b0, 8'h04, 32'h0);
    check("run", 32'(rd[4:0]), 32'h4);
    check("ls_early", 32'(ls_early), 32'h0);
    check("pb_step1", 32'(lw_q[2]), 32'd10);
    check("pb_step2", 32'(lw_q[20]), 32'd20);
    check("sample", 32'(sw_last), 32'd2);
  endtask

  task automatic t_oc();
    overload <= 1'b1;
    wait_for(1, 1'b1, 200);
    repeat (3) @(posedge pclk);
    check("oc_ref", 32'(ss_ref), 32'h0);
    repeat (400) @(posedge pclk);
    check("oc_hold", 32'(oc_fault), 32'h1);
    wait_for(1, 1'b0, 300);
    wait_for(1, 1'b1, 12000);
    overload <= 1'b0;
    wait_for(1, 1'b0, 700);
    apb(1'b0, 8'h0C, 32'h0);
    check("hiccups", rd, 32'h2);
  endtask

  task automatic t_hot();
    thermal_trip <= 1'b1;
    wait_for(2, 1'b1, 20);
    repeat (2) @(posedge pclk);
    check("hot_hs", 32'(high_side_switch), 32'h0);
    check("hot_ls", 32'(low_side_switch), 32'h0);
    check("hot_ref", 32'(ss_ref), 32'h0);
    thermal_trip <= 1'b0;
    wait_for(2, 1'b0, 20);
    repeat (120) @(posedge pclk);
    check("restart", 32'(ss_ref != 12'h000), 32'h1);
  endtask

  task automatic t_bias();
    repeat (11000) @(posedge pclk);
    light_load <= 1'b1;
    repeat (250 * 80) @(posedge pclk);
    check("bias_early", 32'(bias_low), 32'h0);
    wait_for(3, 1'b1, 1000);
    light_load <= 1'b0;
    wait_for(3, 1'b0, 200);
  endtask

  task automatic t_off();
    apb(1'b1, 8'h00, 32'h0);
    wait_for(0, 1'b0, 10);
    apb(1'b1, 8'h00, 32'h1);
    wait_for(0, 1'b1, 10);
    enable_ok <= 1'b0;
    wait_for(0, 1'b0, 10);
    check("off_hs", 32'(high_side_switch), 32'h0);
    check("off_ls", 32'(low_side_switch), 32'h0);
    enable_ok <= 1'b1;
    bias_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    check("nobias", 32'(supply_valid), 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, bias_ok, enable_ok} = '0;
    {thermal_trip, overvoltage, overload, light_load} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    limit_select_strap = 2'h0;
    for (int k = 0; k < 3; k++)
    begin
      limit_select_strap <= 2'(k);
      do_reset();
      repeat (60) @(posedge pclk);
      check("strap", 32'(oc_limit_sel), 32'(k));
    end
    t_regs();
    t_start();
    t_oc();
    t_hot();
    t_bias();
    t_off();
    stop_test();
  end

  // Run limit
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
endmodule
